// ---- pkg/afc_pkg.sv ----
// Purpose: Shared constants for the converter flow access configuration block
// Assumes: AXI4-Lite register bus, 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package afc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_FLOW = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ----------------------------------------
  // Control register 0 fields
  // ----------------------------------------
  localparam int CTRL0_EN_BIT = 15;
  localparam int CTRL0_ACC_HI = 11;
  localparam int CTRL0_ACC_LO = 10;
  localparam int CTRL0_STR_BIT = 9;
  localparam int CTRL0_MOD_BIT = 8;
  localparam logic [15:0] CTRL0_RESET = 16'h0000;

  // ----------------------------------------
  // Access configuration codes
  // ----------------------------------------
  localparam logic [1:0] ACC_NONE = 2'h0;
  localparam logic [1:0] ACC_INTERNAL = 2'h1;
  localparam logic [1:0] ACC_BUS = 2'h2;
  localparam logic [1:0] ACC_DUAL = 2'h3;

  // ----------------------------------------
  // Flow control register fields
  // ----------------------------------------
  localparam int FLOW_LOAD_OK_BIT_BIT = 0;
  localparam int FLOW_TRIGGER_REQUEST_BIT_BIT = 1;
  localparam int FLOW_RESTART_REQUEST_BIT_BIT = 2;
  localparam int FLOW_SEQUENCE_ABORT_BIT_BIT = 3;
  localparam int FLOW_W = 4;
  localparam logic [3:0] FLOW_RESET = 4'h0;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int STS_RESTART_REQUEST_BIT_ERR_BIT = 0;
  localparam int STS_CONV_BIT = 1;
  localparam int STS_LIST_BIT = 2;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ---- src/afc_event_ctl.sv ----
// Purpose: Decides storage and error handling for abort and restart events
// Assumes: Event inputs are one-cycle pulses
// Notes: Purely combinational; the caller registers the outputs
`timescale 1ns/10ps
`default_nettype none

module afc_event_ctl (
  // Configuration
  input wire logic store_on_abort_cfg,
  // Events
  input wire logic abort_evt,
  input wire logic restart_evt,
  input wire logic sequence_abort_bit_pending,
  // Converter state
  input wire logic conv_active,
  input wire logic conv_last,
  input wire logic list_active,
  // Decisions
  output logic store_result,
  output logic set_complete,
  output logic update_interm,
  output logic discard_result,
  output logic restart_err_set,
  output logic hw_sequence_abort_bit_set
);

  logic any_evt;
  logic restart_alone;
  logic in_last;

  assign any_evt = (abort_evt || restart_evt) && conv_active;
  assign restart_alone = restart_evt && !abort_evt && !sequence_abort_bit_pending;
  assign in_last = conv_active && conv_last;

  assign discard_result = any_evt && !store_on_abort_cfg;
  assign store_result = any_evt && store_on_abort_cfg;
  assign set_complete = any_evt && store_on_abort_cfg;
  assign update_interm = any_evt && store_on_abort_cfg;

  always_comb begin
    restart_err_set = 1'b0;
    hw_sequence_abort_bit_set = 1'b0;
    if (restart_alone && list_active) begin
      if (!store_on_abort_cfg) begin
        restart_err_set = 1'b1;
        hw_sequence_abort_bit_set = 1'b1;
      end else if (!in_last) begin
        restart_err_set = 1'b1;
      end else begin
        restart_err_set = 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/afc_top.sv ----
// Purpose: Access configuration and abort handling for the conversion flow register
// Assumes: AXI4-Lite slave, one write and one read under way at a time
// Notes: Internal interface writes arrive as single-cycle strobes
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module afc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Internal flow control interface
  input wire logic int_flow_wr,
  input wire logic [afc_pkg::FLOW_W-1:0] int_flow_data,
  // Converter side
  input wire logic conv_active,
  input wire logic conv_last,
  input wire logic list_active,
  input wire logic [afc_pkg::FLOW_W-1:0] flow_clr,
  // Flow and decisions toward the converter
  output logic [afc_pkg::FLOW_W-1:0] flow_bits,
  output logic flow_trigger_mode,
  output logic store_result,
  output logic set_complete,
  output logic update_interm,
  output logic discard_result
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic bus_path_on(input logic [1:0] acc);
    bus_path_on = (acc == afc_pkg::ACC_BUS) || (acc == afc_pkg::ACC_DUAL);
  endfunction

  function automatic logic int_path_on(input logic [1:0] acc);
    int_path_on = (acc == afc_pkg::ACC_INTERNAL) || (acc == afc_pkg::ACC_DUAL);
  endfunction

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (a == afc_pkg::OFS_CTRL0) begin
      reg_sel = 2'h1;
    end else if (a == afc_pkg::OFS_FLOW) begin
      reg_sel = 2'h2;
    end else if (a == afc_pkg::OFS_STATUS) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] ctrl0_q;
  logic [afc_pkg::FLOW_W-1:0] flow_q;
  logic [afc_pkg::FLOW_W-1:0] flow_d;
  logic restart_request_bit_err_q;
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic store_q;
  logic complete_q;
  logic interm_q;
  logic discard_q;

  logic [1:0] flow_ctl_access_cfg;
  logic wr_fire;
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  logic bus_flow_wr;
  logic int_flow_ok;
  logic [afc_pkg::FLOW_W-1:0] bus_set;
  logic [afc_pkg::FLOW_W-1:0] int_set;
  logic [afc_pkg::FLOW_W-1:0] new_set;
  logic abort_evt;
  logic restart_evt;
  logic ev_store;
  logic ev_complete;
  logic ev_interm;
  logic ev_discard;
  logic ev_err;
  logic ev_hw_sequence_abort_bit;

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  assign flow_ctl_access_cfg = ctrl0_q[afc_pkg::CTRL0_ACC_HI:afc_pkg::CTRL0_ACC_LO];
  assign flow_trigger_mode = ctrl0_q[afc_pkg::CTRL0_MOD_BIT];
  assign flow_bits = flow_q;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wr_sel = reg_sel(awaddr_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bresp_q <= afc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bresp_q <= (wr_sel == 2'h0) ? afc_pkg::RESP_DECERR : afc_pkg::RESP_OKAY;
    end
  end

  // ----------------------------------------
  // Control register 0
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_q <= afc_pkg::CTRL0_RESET;
    end else if (wr_fire && wr_sel == 2'h1) begin
      if (wstrb_q[1]) begin
        ctrl0_q[15:12] <= wdata_q[15:12];
        if (!ctrl0_q[afc_pkg::CTRL0_EN_BIT]) begin
          ctrl0_q[11:8] <= wdata_q[11:8];
        end
      end
    end
  end

  // ----------------------------------------
  // Flow register access paths
  // ----------------------------------------
  assign bus_flow_wr = wr_fire && (wr_sel == 2'h2) && wstrb_q[0];
  assign int_flow_ok = int_flow_wr && int_path_on(flow_ctl_access_cfg);
  assign bus_set = (bus_flow_wr && bus_path_on(flow_ctl_access_cfg)) ?
                   wdata_q[afc_pkg::FLOW_W-1:0] : '0;
  assign int_set = int_flow_ok ? int_flow_data : '0;
  assign new_set = (bus_set | int_set) & ~flow_q;

  assign abort_evt = new_set[afc_pkg::FLOW_SEQUENCE_ABORT_BIT_BIT];
  assign restart_evt = new_set[afc_pkg::FLOW_RESTART_REQUEST_BIT_BIT];

  afc_event_ctl u_event (
    .store_on_abort_cfg(ctrl0_q[afc_pkg::CTRL0_STR_BIT]),
    .abort_evt(abort_evt),
    .restart_evt(restart_evt),
    .sequence_abort_bit_pending(flow_q[afc_pkg::FLOW_SEQUENCE_ABORT_BIT_BIT]),
    .conv_active(conv_active),
    .conv_last(conv_last),
    .list_active(list_active),
    .store_result(ev_store),
    .set_complete(ev_complete),
    .update_interm(ev_interm),
    .discard_result(ev_discard),
    .restart_err_set(ev_err),
    .hw_sequence_abort_bit_set(ev_hw_sequence_abort_bit)
  );

  // Set from either path wins over a converter clear
  always_comb begin
    flow_d = (flow_q & ~flow_clr) | bus_set | int_set;
    if (ev_hw_sequence_abort_bit) begin
      flow_d[afc_pkg::FLOW_SEQUENCE_ABORT_BIT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flow_q <= afc_pkg::FLOW_RESET;
    end else begin
      flow_q <= flow_d;
    end
  end

  // ----------------------------------------
  // Restart error flag, write one to clear
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_request_bit_err_q <= 1'b0;
    end else if (ev_err) begin
      restart_request_bit_err_q <= 1'b1;
    end else if (wr_fire && wr_sel == 2'h3 && wstrb_q[0] && wdata_q[afc_pkg::STS_RESTART_REQUEST_BIT_ERR_BIT]) begin
      restart_request_bit_err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Result handling strobes
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      store_q <= 1'b0;
    end else begin
      store_q <= ev_store;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      complete_q <= 1'b0;
    end else begin
      complete_q <= ev_complete;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interm_q <= 1'b0;
    end else begin
      interm_q <= ev_interm;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= ev_discard;
    end
  end

  assign store_result = store_q;
  assign set_complete = complete_q;
  assign update_interm = interm_q;
  assign discard_result = discard_q;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_sel = reg_sel(s_axi_araddr);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= afc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= afc_pkg::RESP_OKAY;
      case (rd_sel)
        2'h1: begin
          rdata_q <= {16'h0000, ctrl0_q};
        end
        2'h2: begin
          rdata_q <= {28'h0000000, flow_q};
        end
        2'h3: begin
          rdata_q <= {29'h00000000, list_active, conv_active, restart_request_bit_err_q};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= afc_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/afc_top_properties.sv ----
// Purpose: Port checks for the flow access block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to afc_top
`timescale 1ns/10ps
`default_nettype none
module afc_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Flow side
  input wire logic int_flow_wr,
  input wire logic conv_active,
  input wire logic [afc_pkg::FLOW_W-1:0] flow_clr,
  input wire logic [afc_pkg::FLOW_W-1:0] flow_bits,
  input wire logic flow_trigger_mode,
  input wire logic store_result,
  input wire logic set_complete,
  input wire logic update_interm,
  input wire logic discard_result
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_flow_cause: assert property (|(flow_bits & ~$past(flow_bits)) |-> $past(int_flow_wr) || $rose(s_axi_bvalid))
    else $error("flow bit set without a write");
  chk_mode_cause: assert property ($changed(flow_trigger_mode) |-> $rose(s_axi_bvalid))
    else $error("mode changed without a write");
  chk_clr_wins: assert property (flow_clr != 0 && !int_flow_wr && !s_axi_awvalid && !s_axi_wvalid
    && !$past(s_axi_awvalid) && !$past(s_axi_wvalid) |=> (flow_bits & $past(flow_clr)) == 0)
    else $error("flow bit not cleared");
  chk_store_set: assert property (store_result |-> set_complete && update_interm && !discard_result)
    else $error("store without complete and info");
  chk_discard_only: assert property (discard_result |-> !set_complete && !store_result && !update_interm)
    else $error("discard with complete flag");
  chk_store_cause: assert property ($rose(store_result)
    |-> $past(conv_active) && ($past(int_flow_wr) || $rose(s_axi_bvalid)))
    else $error("store without event");
  chk_discard_cause: assert property (discard_result |-> $past(conv_active))
    else $error("discard outside a conversion");
  cover property (store_result);
  cover property (discard_result);
  cover property (s_axi_bvalid && s_axi_bresp == afc_pkg::RESP_DECERR);
endmodule
bind afc_top afc_top_checker u_chk (.clk, .reset_n, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .int_flow_wr, .conv_active, .flow_clr, .flow_bits, .flow_trigger_mode, .store_result,
  .set_complete, .update_interm, .discard_result);
`default_nettype wire

// ---- testbench/afc_flow_partner.sv ----
// Purpose: Converter and internal flow interface model
// Assumes: Commands from the bench one cycle ahead
// Notes: Data lines toggle while no strobe is given
`timescale 1ns/10ps
`default_nettype none
module afc_flow_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic cmd_wr,
  input wire logic [3:0] cmd_data,
  input wire logic [2:0] cmd_state,
  input wire logic [3:0] cmd_clr,
  // Toward the block
  output logic int_flow_wr,
  output logic [3:0] int_flow_data,
  output logic conv_active,
  output logic conv_last,
  output logic list_active,
  output logic [3:0] flow_clr
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_flow_wr <= 1'b0;
      int_flow_data <= 4'h0;
    end else begin
      int_flow_wr <= cmd_wr;
      int_flow_data <= cmd_wr ? cmd_data : ~int_flow_data;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {list_active, conv_last, conv_active} <= 3'h0;
      flow_clr <= 4'h0;
    end else begin
      {list_active, conv_last, conv_active} <= cmd_state;
      flow_clr <= cmd_clr;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/adc_flow_access_config_tb.sv ----
// Purpose: Self-checking bench for the flow access block
// Assumes: Expected results queued by the drivers and the scenarios
// Notes: Bus results and result pulses are compared at the falling edge
`timescale 1ns/10ps
`default_nettype none
module adc_flow_access_config_tb;
  logic clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cmd_wr = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] cmd_data = 0, cmd_clr = 0;
  logic [2:0] cmd_state = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, int_flow_wr;
  wire logic conv_active, conv_last, list_active, store_result, set_complete, update_interm, discard_result;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0] int_flow_data, flow_clr, flow_bits;
  wire logic flow_trigger_mode;
  int num_errors = 0, compares = 0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [3:0] exp_p[$];

  afc_top u_dut (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .int_flow_wr, .int_flow_data, .conv_active, .conv_last,
    .list_active, .flow_clr, .flow_bits, .flow_trigger_mode, .store_result, .set_complete,
    .update_interm, .discard_result);
  afc_flow_partner u_partner (.clk, .reset_n, .cmd_wr, .cmd_data, .cmd_state, .cmd_clr, .int_flow_wr,
    .int_flow_data, .conv_active, .conv_last, .list_active, .flow_clr);

  initial begin
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      num_errors++;
      $display("CHECK FAILED bus wait expected answer seen none");
      tally_and_finish();
    end
  endtask
  task automatic cmp_read(input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED read exp %h seen %h", e, s);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED bresp exp %h seen %h", e, s);
    end
  endtask
  task automatic cmp_pin(input string nm, input logic [3:0] e, input logic [3:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_pulse(input logic [3:0] e, input logic [3:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED pulses exp %h seen %h", e, s);
    end
  endtask
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_read(exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp_resp(exp_b.pop_front(), s_axi_bresp);
    if (store_result || set_complete || update_interm || discard_result)
      cmp_pulse(exp_p.pop_front(), {store_result, set_complete, update_interm, discard_result});
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd, bt;
    int n;
    ad = 0;
    wd = 0;
    n = 0;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      bt = s_axi_bvalid;
      if (!ad && s_axi_awready) s_axi_awvalid <= @(posedge clk) 1'b0;
      if (!wd && s_axi_wready) s_axi_wvalid <= @(posedge clk) 1'b0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      @(posedge clk);
      guard(n);
    end while (!bt);
  endtask
  task automatic bus_read(input logic [7:0] a, input logic [33:0] e);
    logic t;
    int n;
    n = 0;
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      t = s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= @(posedge clk) 1'b0;
      @(posedge clk);
      guard(n);
    end while (!t);
  endtask
  task automatic int_write(input logic [3:0] d);
    cmd_wr <= 1'b1;
    cmd_data <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic flush();
    cmd_state <= 3'h0;
    cmd_clr <= 4'hf;
    @(posedge clk);
    cmd_clr <= 4'h0;
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic m;
    void'($urandom(32912));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus_read(8'h00, 34'h0);
    bus_read(8'h0c, {2'h3, 32'h0});
    bus_write(8'h0c, 32'h1, 2'h3);
    for (int c = 0; c < 4; c++) begin
      m = $urandom_range(0, 1);
      bus_write(8'h00, {20'h0, c[1:0], 1'b0, m, 8'h0}, 2'h0);
      cmp_pin("flow_trigger_mode", {3'h0, m}, {3'h0, flow_trigger_mode});
      bus_read(8'h00, {2'h0, 20'h0, c[1:0], 1'b0, m, 8'h0});
      bus_write(8'h04, 32'h1, 2'h0);
      int_write(4'h2);
      bus_read(8'h04, {2'h0, 30'h0, c[0], c[1]});
      cmp_pin("flow_bits", {2'h0, c[0], c[1]}, flow_bits);
      flush();
    end
    for (int s = 0; s < 2; s++) begin
      for (int l = 0; l < 2; l++) begin
        bus_write(8'h00, {20'h0, 2'h3, s[0], 9'h0}, 2'h0);
        cmd_state <= {1'b1, l[0], 1'b1};
        @(posedge clk);
        exp_p.push_back(s[0] ? 4'he : 4'h1);
        int_write(4'h4);
        bus_read(8'h08, {2'h0, 29'h0, 2'h3, ~(s[0] & l[0])});
        bus_read(8'h04, {2'h0, 28'h0, ~s[0], 3'h4});
        cmp_pin("flow_bits", {~s[0], 3'h4}, flow_bits);
        bus_write(8'h08, 32'h1, 2'h0);
        bus_read(8'h08, {2'h0, 29'h0, 2'h3, 1'b0});
        flush();
      end
    end
    bus_write(8'h00, 32'h0000_8000, 2'h0);
    bus_write(8'h00, 32'h0000_8f00, 2'h0);
    bus_read(8'h00, {2'h0, 32'h0000_8000});
    if (exp_r.size() + exp_b.size() + exp_p.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED queues exp 0 seen %0d", exp_r.size() + exp_b.size() + exp_p.size());
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
